// >>> core/viu_pkg.sv
// package of constants and carriers for the vectored interrupt unit
package viu_pkg;

  // ==========================================================
  // source ranking and vectors
  localparam int NSRC = 8;
  localparam logic [7:0] TRAP_OPCODE = 8'h00;
  localparam logic [14:0] ENTRY_ADDR = 15'h00ff;
  localparam real CLK_MHZ = 10.0;
  localparam int ENTRY_TC = 7;
  localparam int ENTRY_CYCLES = ENTRY_TC;
  localparam logic [2:0] ENTRY_LAST = 3'(ENTRY_CYCLES - 1);
  localparam logic [7:0] VEC_TRAP = 8'hfe;
  localparam logic [7:0] VEC_DEFAULT = 8'he0;
  // index 0 is the highest ranked maskable source
  localparam logic [7:0] VEC_OFS [NSRC] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4,
                                             8'hf2, 8'hea, 8'he8, 8'he2};
  localparam logic [7:0] PAGE_LAST = 8'hff;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_PENDING = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_GIE_BIT = 0;
  localparam int STAT_TRAP_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_ACTIVE_LSB = 8;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PENDING_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // carriers to and from the instruction sequencer
  typedef struct packed {
    logic boundary;
    logic [7:0] opcode;
    logic [14:0] pc;
    logic vis_exec;
    logic [14:0] vis_pc;
    logic return_from_handler_insn_exec;
    logic clear_trap_pending_insn_exec;
    logic vec_valid;
    logic [7:0] vec_hi;
    logic [7:0] vec_lo;
  } viu_seq_in_t;

  typedef struct packed {
    logic jam;
    logic [7:0] opcode;
    logic push_valid;
    logic [14:0] push_addr;
    logic branch_valid;
    logic [14:0] branch_addr;
    logic entry_busy;
    logic vec_req;
    logic [14:0] vec_addr;
    logic jump_valid;
    logic [14:0] jump_addr;
  } viu_seq_out_t;

  typedef enum logic [1:0] {VIU_IDLE, VIU_ENTRY} viu_entry_t;
  typedef enum logic [1:0] {VIU_VS_IDLE, VIU_VS_WAIT} viu_vis_t;

endpackage

// >>> core/viu_top.sv
// vectored interrupt unit with axi4-lite register slave
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module viu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [viu_pkg::NSRC-1:0] src_req,
  input wire viu_pkg::viu_seq_in_t seq_in,
  output viu_pkg::viu_seq_out_t seq_out,
  input wire logic [viu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [viu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // state
  viu_pkg::viu_entry_t state_reg;
  viu_pkg::viu_vis_t vis_reg;
  logic [2:0] cnt_reg;
  logic busy_reg;
  logic gie_reg;
  logic trap_reg;
  logic fault_reg;
  logic [viu_pkg::NSRC-1:0] enable_reg;
  logic [viu_pkg::NSRC-1:0] pend_reg;
  logic [viu_pkg::NSRC-1:0] pend_next;
  logic jam_reg;
  logic push_reg;
  logic [14:0] push_addr_reg;
  logic branch_reg;
  logic vec_req_reg;
  logic [14:0] vec_addr_reg;
  logic jump_reg;
  logic [14:0] jump_addr_reg;
  logic [7:0] op_reg;

  logic [viu_pkg::NSRC-1:0] active;
  logic take_now;
  logic trap_now;
  logic [7:0] sel_ofs;
  logic [6:0] vis_page;

  // ==========================================================
  // axi signals
  logic aw_have_reg;
  logic w_have_reg;
  logic [viu_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic ctrl_wr;
  logic en_wr;
  logic pend_wr;
  logic stat_wr;
  logic wr_mapped;

  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  assign ar_hs = s_axi_arvalid && arready_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  // ==========================================================
  // arbitration
  assign active = enable_reg & pend_reg;
  // decided combinationally at the boundary, so an enable cleared in the same cycle still races
  assign take_now = gie_reg && (|active) && !trap_reg;
  assign trap_now = (seq_in.opcode == viu_pkg::TRAP_OPCODE) && !take_now;

  always_comb begin
    sel_ofs = viu_pkg::VEC_DEFAULT;
    for (int i = viu_pkg::NSRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        sel_ofs = viu_pkg::VEC_OFS[i];
      end
    end
    if (trap_reg) begin
      sel_ofs = viu_pkg::VEC_TRAP;
    end
  end

  // a select on the last byte of a page reads its table from the next page
  always_comb begin
    if (seq_in.vis_pc[7:0] == viu_pkg::PAGE_LAST) begin
      vis_page = 7'(seq_in.vis_pc[14:8] + 7'h01);
    end else begin
      vis_page = seq_in.vis_pc[14:8];
    end
  end

  // ==========================================================
  // entry sequence
  // busy gets its own flop so the sequencer sees a registered level, not a state decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= viu_pkg::VIU_IDLE;
      cnt_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else begin
      case (state_reg)
        viu_pkg::VIU_IDLE: begin
          if (seq_in.boundary && (take_now || trap_now)) begin
            state_reg <= viu_pkg::VIU_ENTRY;
            cnt_reg <= viu_pkg::ENTRY_LAST;
            busy_reg <= 1'b1;
          end
        end
        viu_pkg::VIU_ENTRY: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            state_reg <= viu_pkg::VIU_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= viu_pkg::VIU_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jam_reg <= 1'b0;
      push_reg <= 1'b0;
      push_addr_reg <= 15'h0000;
      branch_reg <= 1'b0;
      op_reg <= viu_pkg::TRAP_OPCODE;
    end else begin
      jam_reg <= (state_reg == viu_pkg::VIU_IDLE) && seq_in.boundary && take_now;
      push_reg <= (state_reg == viu_pkg::VIU_IDLE) && seq_in.boundary && (take_now || trap_now);
      if ((state_reg == viu_pkg::VIU_IDLE) && seq_in.boundary) begin
        push_addr_reg <= seq_in.pc;
      end
      branch_reg <= (state_reg == viu_pkg::VIU_ENTRY) && (cnt_reg == 3'h1);
      op_reg <= viu_pkg::TRAP_OPCODE;
    end
  end

  // ==========================================================
  // global enable, trap pending, pending bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_reg <= 1'b0;
    end else if ((state_reg == viu_pkg::VIU_IDLE) && seq_in.boundary && take_now) begin
      gie_reg <= 1'b0;
    end else if (seq_in.return_from_handler_insn_exec) begin
      gie_reg <= 1'b1;
    end else if (ctrl_wr) begin
      gie_reg <= wdata_reg[viu_pkg::CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_reg <= 1'b0;
    end else if ((state_reg == viu_pkg::VIU_IDLE) && seq_in.boundary && trap_now) begin
      trap_reg <= 1'b1;
    end else if (seq_in.clear_trap_pending_insn_exec) begin
      trap_reg <= 1'b0;
    end
  end

  // a request in the cycle of a software clear wins; entry never clears it
  always_comb begin
    pend_next = pend_reg;
    if (pend_wr) begin
      pend_next = pend_reg & ~wdata_reg[viu_pkg::NSRC-1:0];
    end
    pend_next = pend_next | src_req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= viu_pkg::PENDING_RST;
      enable_reg <= viu_pkg::ENABLE_RST;
    end else begin
      pend_reg <= pend_next;
      if (en_wr) begin
        enable_reg <= wdata_reg[viu_pkg::NSRC-1:0];
      end
    end
  end

  // ==========================================================
  // vector select and table fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vis_reg <= viu_pkg::VIU_VS_IDLE;
      vec_req_reg <= 1'b0;
      vec_addr_reg <= 15'h0000;
      jump_reg <= 1'b0;
      jump_addr_reg <= 15'h0000;
    end else begin
      vec_req_reg <= 1'b0;
      jump_reg <= 1'b0;
      case (vis_reg)
        viu_pkg::VIU_VS_IDLE: begin
          if (seq_in.vis_exec) begin
            vec_addr_reg <= {vis_page, sel_ofs};
            vec_req_reg <= 1'b1;
            vis_reg <= viu_pkg::VIU_VS_WAIT;
          end
        end
        viu_pkg::VIU_VS_WAIT: begin
          if (seq_in.vec_valid) begin
            jump_addr_reg <= {seq_in.vec_hi[6:0], seq_in.vec_lo};
            jump_reg <= 1'b1;
            vis_reg <= viu_pkg::VIU_VS_IDLE;
          end
        end
        default: vis_reg <= viu_pkg::VIU_VS_IDLE;
      endcase
    end
  end

  // page zero is illegal for the table; flagged, not blocked, so the core does not hang
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg <= 1'b0;
    end else if (seq_in.vis_exec && (vis_reg == viu_pkg::VIU_VS_IDLE) && (vis_page == 7'h00)) begin
      fault_reg <= 1'b1;
    end else if (stat_wr && wdata_reg[viu_pkg::STAT_FAULT_BIT]) begin
      fault_reg <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite write path
  always_comb begin
    ctrl_wr = 1'b0;
    en_wr = 1'b0;
    pend_wr = 1'b0;
    stat_wr = 1'b0;
    wr_mapped = 1'b1;
    if (awaddr_reg == viu_pkg::ADDR_CTRL) begin
      ctrl_wr = wr_fire && wstrb_reg[0];
    end else if (awaddr_reg == viu_pkg::ADDR_ENABLE) begin
      en_wr = wr_fire && wstrb_reg[0];
    end else if (awaddr_reg == viu_pkg::ADDR_PENDING) begin
      pend_wr = wr_fire && wstrb_reg[0];
    end else if (awaddr_reg == viu_pkg::ADDR_STATUS) begin
      stat_wr = wr_fire && wstrb_reg[0];
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      awready_reg <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      awready_reg <= !aw_hs && !aw_have_reg && !bvalid_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      wready_reg <= 1'b0;
    end else begin
      if (w_hs) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      wready_reg <= !w_hs && !w_have_reg && !bvalid_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= viu_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? viu_pkg::RESP_OKAY : viu_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= viu_pkg::RESP_OKAY;
    end else begin
      arready_reg <= !ar_hs && !rvalid_reg;
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= viu_pkg::RESP_OKAY;
        rdata_reg <= 32'h0000_0000;
        if (s_axi_araddr == viu_pkg::ADDR_CTRL) begin
          rdata_reg[viu_pkg::CTRL_GIE_BIT] <= gie_reg;
        end else if (s_axi_araddr == viu_pkg::ADDR_ENABLE) begin
          rdata_reg[viu_pkg::NSRC-1:0] <= enable_reg;
        end else if (s_axi_araddr == viu_pkg::ADDR_PENDING) begin
          rdata_reg[viu_pkg::NSRC-1:0] <= pend_reg;
        end else if (s_axi_araddr == viu_pkg::ADDR_STATUS) begin
          rdata_reg[viu_pkg::STAT_TRAP_BIT] <= trap_reg;
          rdata_reg[viu_pkg::STAT_BUSY_BIT] <= (state_reg == viu_pkg::VIU_ENTRY);
          rdata_reg[viu_pkg::STAT_FAULT_BIT] <= fault_reg;
          rdata_reg[viu_pkg::STAT_ACTIVE_LSB +: viu_pkg::NSRC] <= active;
        end else begin
          rresp_reg <= viu_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign seq_out = '{jam: jam_reg, opcode: op_reg, push_valid: push_reg,
                     push_addr: push_addr_reg, branch_valid: branch_reg,
                     branch_addr: viu_pkg::ENTRY_ADDR,
                     entry_busy: busy_reg,
                     vec_req: vec_req_reg, vec_addr: vec_addr_reg,
                     jump_valid: jump_reg, jump_addr: jump_addr_reg};

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_entry_clears_gie: assert property (
    jam_reg |-> !gie_reg && push_reg && seq_out.entry_busy)
    else $error("entry did not clear global enable");
  chk_entry_length: assert property (
    $rose(seq_out.entry_busy) |-> seq_out.entry_busy [*7] ##1 !seq_out.entry_busy)
    else $error("entry did not last seven cycles");
  chk_branch_target: assert property (
    $rose(seq_out.entry_busy) |-> ##6 (branch_reg && seq_out.branch_addr == 15'h00ff))
    else $error("branch to entry address missing");
  chk_jam_opcode: assert property (
    jam_reg |-> seq_out.opcode == 8'h00 && $past(gie_reg) && !$past(trap_reg))
    else $error("jam without trap opcode or enable");
  chk_take_irq: assert property (
    (state_reg == viu_pkg::VIU_IDLE && seq_in.boundary && gie_reg && |active && !trap_reg)
    |=> jam_reg && push_addr_reg == $past(seq_in.pc))
    else $error("active source not taken at boundary");
  chk_trap_keeps_gie: assert property (
    (state_reg == viu_pkg::VIU_IDLE && seq_in.boundary && trap_now && !seq_in.return_from_handler_insn_exec && !ctrl_wr)
    |=> trap_reg && !jam_reg && gie_reg == $past(gie_reg))
    else $error("trap changed enable or missed pending");
  chk_trap_blocks: assert property (
    (trap_reg && seq_in.boundary) |=> !jam_reg)
    else $error("maskable entry during trap service");
  chk_pending_set: assert property (
    |src_req |=> (pend_reg & $past(src_req)) == $past(src_req))
    else $error("request lost from pending");
  chk_return_from_handler_insn_sets_gie: assert property (
    (seq_in.return_from_handler_insn_exec && !(seq_in.boundary && take_now)) |=> gie_reg)
    else $error("return did not set enable");
  chk_clear_trap_pending_insn_clears: assert property (
    (seq_in.clear_trap_pending_insn_exec && !(seq_in.boundary && trap_now)) |=> !trap_reg)
    else $error("trap pending not cleared");
  chk_vis_default: assert property (
    (seq_in.vis_exec && vis_reg == viu_pkg::VIU_VS_IDLE && !trap_reg && active == 8'h00)
    |=> vec_req_reg && vec_addr_reg[7:0] == 8'he0)
    else $error("default vector not selected");
  chk_vis_trap: assert property (
    (seq_in.vis_exec && vis_reg == viu_pkg::VIU_VS_IDLE && trap_reg)
    |=> vec_addr_reg[7:0] == 8'hfe)
    else $error("trap vector not selected");

  cov_irq_entry: cover property (jam_reg ##[1:20] branch_reg);
  cov_trap_entry: cover property ($rose(trap_reg) ##[1:40] jump_reg);
  cov_return_from_handler_insn_again: cover property (seq_in.return_from_handler_insn_exec ##[1:10] jam_reg);
  cov_axi_write: cover property (wr_fire && pend_wr);

endmodule // viu_top
`default_nettype wire

// >>> bench/viu_seq_model.sv
// sequencer-side model that fetches vector bytes from program memory
`timescale 1ns/1ps
`default_nettype none
module viu_seq_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic vec_req,
  input wire logic [14:0] vec_addr,
  output logic vec_valid,
  output logic [7:0] vec_hi,
  output logic [7:0] vec_lo
);
  // ==========================================================
  // program memory fetch
  logic busy;
  logic [3:0] wait_cnt;
  logic [14:0] addr_reg;

  // contents are arbitrary: each byte depends on its own address
  function automatic logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      addr_reg <= 15'h0000;
      vec_valid <= 1'b0;
      vec_hi <= 8'h00;
      vec_lo <= 8'hff;
    end else begin
      vec_valid <= 1'b0;
      if (vec_req) begin
        busy <= 1'b1;
        addr_reg <= vec_addr;
        wait_cnt <= slow ? 4'h5 : 4'h0;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        vec_valid <= 1'b1;
        vec_hi <= rom(addr_reg);
        vec_lo <= rom(addr_reg + 15'h0001);
      end else begin
        // bytes toggle when idle so stale data never looks valid
        vec_hi <= ~vec_hi;
        vec_lo <= ~vec_lo;
      end
    end
  end
endmodule // viu_seq_model
`default_nettype wire

// >>> bench/tb_viu_top.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_viu_top;
  logic aclk;
  logic aresetn;
  logic [7:0] src_req;
  logic bnd, vector_select_insn, return_from_handler_insn, clear_trap_pending_insn, slow, vvalid;
  logic [7:0] opc, vhi, vlo;
  logic [14:0] pc;
  viu_pkg::viu_seq_in_t seq_in;
  viu_pkg::viu_seq_out_t seq_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int err_total, total_checks;
  logic [7:0] ofs [8] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hea, 8'he8, 8'he2};

  assign seq_in = '{boundary: bnd, opcode: opc, pc: pc, vis_exec: vector_select_insn, vis_pc: pc,
    return_from_handler_insn_exec: return_from_handler_insn, clear_trap_pending_insn_exec: clear_trap_pending_insn, vec_valid: vvalid, vec_hi: vhi, vec_lo: vlo};

  viu_top viu_top_i (.aclk(aclk), .aresetn(aresetn), .src_req(src_req), .seq_in(seq_in),
    .seq_out(seq_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  viu_seq_model viu_seq_model_i (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .vec_req(seq_out.vec_req), .vec_addr(seq_out.vec_addr), .vec_valid(vvalid),
    .vec_hi(vhi), .vec_lo(vlo));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ==========================================================
  // shared tasks
  function automatic logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hung(input string nm);
    err_total++;
    $display("wrong value %s expected handshake seen none", nm);
    give_verdict();
  endtask

  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [2:0] go;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(negedge aclk);
      go = {awvalid && awready, wvalid && wready, bready && bvalid};
      r = bresp;
      @(posedge aclk);
      if (go[2]) awvalid <= 1'b0;
      if (go[1]) wvalid <= 1'b0;
      if (go[0]) bready <= 1'b0;
      n++;
    end while (n < 40 && go[0] == 1'b0);
    if (go[0] == 1'b0) hung("bvalid");
    cmp("bresp", er, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [1:0] go;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(negedge aclk);
      go = {arvalid && arready, rready && rvalid};
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (go[1]) arvalid <= 1'b0;
      if (go[0]) rready <= 1'b0;
      n++;
    end while (n < 40 && go[0] == 1'b0);
    if (go[0] == 1'b0) hung("rvalid");
    cmp("rdata", ed, d);
    cmp("rresp", er, r);
  endtask

  // one-cycle sequencer pulse; returns just after the edge that answers it
  task automatic pulse(input logic [3:0] m, input logic [14:0] p, input logic [7:0] o);
    @(posedge aclk);
    {clear_trap_pending_insn, return_from_handler_insn, vector_select_insn, bnd} <= m;
    pc <= p;
    opc <= o;
    @(posedge aclk);
    {clear_trap_pending_insn, return_from_handler_insn, vector_select_insn, bnd} <= 4'h0;
    #1;
  endtask

  task automatic raise(input logic [7:0] m);
    @(posedge aclk);
    src_req <= m;
    @(posedge aclk);
    src_req <= 8'h00;
  endtask

  // mode 0: nothing taken, 1: interrupt entry, 2: software trap entry
  task automatic entry(input int mode, input logic [14:0] p, input logic [7:0] o);
    int n;
    pulse(4'h1, p, o);
    cmp("jam", mode == 1, seq_out.jam);
    cmp("push_valid", mode != 0, seq_out.push_valid);
    if (mode != 0) begin
      cmp("jam_opcode", 8'h00, seq_out.opcode);
      cmp("push_addr", p, seq_out.push_addr);
      n = 1;
      while (seq_out.branch_valid !== 1'b1 && n < 20) begin
        @(posedge aclk);
        #1;
        n++;
      end
      cmp("entry_cycles", 7, n);
      cmp("branch_addr", 15'h00ff, seq_out.branch_addr);
      @(posedge aclk);
      #1;
      cmp("entry_busy", 1'b0, seq_out.entry_busy);
    end
  endtask

  task automatic do_vis(input logic [14:0] p, input logic [7:0] of);
    logic [14:0] a;
    logic [7:0] hi;
    int n;
    n = 0;
    a = {p[14:8] + 7'(p[7:0] == 8'hff), of};
    hi = rom(a);
    pulse(4'h2, p, 8'h12);
    cmp("vec_req", 1'b1, seq_out.vec_req);
    cmp("vec_addr", a, seq_out.vec_addr);
    while (seq_out.jump_valid !== 1'b1 && n < 20) begin
      @(posedge aclk);
      #1;
      n++;
    end
    if (seq_out.jump_valid !== 1'b1) hung("jump_valid");
    cmp("jump_addr", {hi[6:0], rom(a + 15'h0001)}, seq_out.jump_addr);
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_regs;
    axi_rd(viu_pkg::ADDR_ENABLE, 32'h0000_0000, viu_pkg::RESP_OKAY);
    axi_rd(viu_pkg::ADDR_PENDING, 32'h0000_0000, viu_pkg::RESP_OKAY);
    axi_rd(viu_pkg::ADDR_STATUS, 32'h0000_0000, viu_pkg::RESP_OKAY);
    axi_rd(8'h10, 32'h0000_0000, viu_pkg::RESP_SLVERR);
    axi_wr(8'h14, 32'h0000_00ff, viu_pkg::RESP_SLVERR);
    // a write without the low byte strobe must leave the enables untouched
    wstrb <= 4'he;
    axi_wr(viu_pkg::ADDR_ENABLE, 32'h0000_00ff, viu_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(viu_pkg::ADDR_ENABLE, 32'h0000_0000, viu_pkg::RESP_OKAY);
  endtask

  task automatic sc_mask;
    axi_wr(viu_pkg::ADDR_CTRL, 32'h0000_0001, viu_pkg::RESP_OKAY);
    raise(8'h01);
    axi_rd(viu_pkg::ADDR_PENDING, 32'h0000_0001, viu_pkg::RESP_OKAY);
    entry(0, 15'h0100, 8'h12);
    axi_wr(viu_pkg::ADDR_ENABLE, 32'h0000_0001, viu_pkg::RESP_OKAY);
    axi_rd(viu_pkg::ADDR_STATUS, 32'h0000_0100, viu_pkg::RESP_OKAY);
    axi_wr(viu_pkg::ADDR_CTRL, 32'h0000_0000, viu_pkg::RESP_OKAY);
    entry(0, 15'h0100, 8'h12);
  endtask

  task automatic sc_entry;
    axi_wr(viu_pkg::ADDR_ENABLE, 32'h0000_0081, viu_pkg::RESP_OKAY);
    raise(8'h80);
    axi_wr(viu_pkg::ADDR_CTRL, 32'h0000_0001, viu_pkg::RESP_OKAY);
    entry(1, 15'h1234, 8'h12);
    axi_rd(viu_pkg::ADDR_CTRL, 32'h0000_0000, viu_pkg::RESP_OKAY);
    do_vis(15'h0340, 8'hfa);
    axi_wr(viu_pkg::ADDR_PENDING, 32'h0000_0001, viu_pkg::RESP_OKAY);
    pulse(4'h4, 15'h0350, 8'h12);
    axi_rd(viu_pkg::ADDR_CTRL, 32'h0000_0001, viu_pkg::RESP_OKAY);
    entry(1, 15'h0352, 8'h12);
    slow <= 1'b1;
    do_vis(15'h02ff, 8'he2);
    slow <= 1'b0;
    axi_wr(viu_pkg::ADDR_PENDING, 32'h0000_0080, viu_pkg::RESP_OKAY);
  endtask

  task automatic sc_rank;
    axi_wr(viu_pkg::ADDR_ENABLE, 32'h0000_00ff, viu_pkg::RESP_OKAY);
    raise(8'hff);
    for (int i = 0; i < 8; i++) begin
      do_vis(15'h0500, ofs[i]);
      axi_wr(viu_pkg::ADDR_PENDING, 32'h0000_0001 << i, viu_pkg::RESP_OKAY);
    end
    do_vis(15'h0010, 8'he0);
    axi_rd(viu_pkg::ADDR_STATUS, 32'h0000_0004, viu_pkg::RESP_OKAY);
    axi_wr(viu_pkg::ADDR_STATUS, 32'h0000_0004, viu_pkg::RESP_OKAY);
  endtask

  task automatic sc_trap;
    axi_wr(viu_pkg::ADDR_CTRL, 32'h0000_0001, viu_pkg::RESP_OKAY);
    entry(2, 15'h7ffe, 8'h00);
    axi_rd(viu_pkg::ADDR_CTRL, 32'h0000_0001, viu_pkg::RESP_OKAY);
    axi_rd(viu_pkg::ADDR_STATUS, 32'h0000_0001, viu_pkg::RESP_OKAY);
    raise(8'h04);
    entry(0, 15'h0200, 8'h12);
    do_vis(15'h0600, 8'hfe);
    pulse(4'h8, 15'h0200, 8'h12);
    axi_rd(viu_pkg::ADDR_STATUS, 32'h0000_0400, viu_pkg::RESP_OKAY);
    entry(1, 15'h0200, 8'h12);
  endtask

  initial begin
    {src_req, bnd, vector_select_insn, return_from_handler_insn, clear_trap_pending_insn, slow, opc, pc} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    err_total = 0;
    total_checks = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    sc_regs();
    sc_mask();
    sc_entry();
    sc_rank();
    sc_trap();
    give_verdict();
  end
endmodule // tb_viu_top
`default_nettype wire
